//--- rxp_fifo.sv
// flop based receive fifo with valid/ready on both sides
`timescale 1ns/1ps
module rxp_fifo #(
  parameter int WIDTH = 7,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  rxp_stream_if.fifo s
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = s.wr_valid && !full;
  wire pop = s.rd_ready && !empty;

  assign s.wr_ready = !full;
  assign s.rd_valid = !empty;
  assign s.rd_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + {{AW{1'b0}}, 1'b1};
      if (pop) rd_ptr <= rd_ptr + {{AW{1'b0}}, 1'b1};
    end
  end

  // storage needs no reset; empty masks stale words
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr[AW-1:0]] <= s.wr_data;
  end
endmodule

//--- rxp_map.svh
// constants for the receive pin interface and management pins
`ifndef RXP_MAP_SVH
`define RXP_MAP_SVH

// ==================================================
// timing
`define RXP_SYS_PERIOD_NS 50
`define RXP_CLK10_PERIOD_NS 400
`define RXP_CLK100_PERIOD_NS 40
`define RXP_CLKRMII_PERIOD_NS 20
`define RXP_HALF_CYC(p) ((((p) / 2) / `RXP_SYS_PERIOD_NS) > 0 ? (((p) / 2) / `RXP_SYS_PERIOD_NS) : 1)
`define RXP_HALF10 `RXP_HALF_CYC(`RXP_CLK10_PERIOD_NS)
`define RXP_HALF100 `RXP_HALF_CYC(`RXP_CLK100_PERIOD_NS)
`define RXP_HALFRMII `RXP_HALF_CYC(`RXP_CLKRMII_PERIOD_NS)

// ==================================================
// bootstrap bit positions within the captured pin vector {er, dv, d[3:0]}
`define RXP_STRAP_RMII 0
`define RXP_STRAP_SLAVE 1
`define RXP_STRAP_REPEATER 2
`define RXP_STRAP_SPEED100 3
`define RXP_STRAP_ERR 5
`define RXP_CFG_RST 5'h00

// ==================================================
// buffering and management frame
`define RXP_FIFO_WIDTH 7
`define RXP_FIFO_DEPTH 8
`define RXP_PHY_ADDR 5'h01
`define RXP_MD_PRE_BITS 6'h20
`define RXP_MD_HDR_LAST 5'h0C
`define RXP_MD_DATA_BITS 5'h10
`define RXP_MD_WR_BITS 5'h12
`define RXP_MD_OP_READ 2'h2
`define RXP_MD_OP_WRITE 2'h1

`endif

//--- rxp_mgmt_station.sv
// station management model that runs frames on the management clock and data pins
`timescale 1ns/1ps
module rxp_mgmt_station (
  input wire logic mdio_i,
  input wire logic dev_oe_i,
  output logic mdc_o,
  output logic md_oe_o,
  output logic md_o
);
  // ==================================================
  // frame engine
  // 2.3 MHz: far under the ceiling, and slow enough for the device's own sampling
  localparam int HALF_NS = 215;
  logic drove;

  initial begin
    mdc_o = 1'b0;
    md_oe_o = 1'b0;
    md_o = 1'b1;
    drove = 1'b0;
  end

  always @(posedge mdc_o) begin
    if (dev_oe_i) begin
      drove = 1'b1;
    end
  end

  // bits change while the clock is low; the device samples them on the rise
  task automatic put_bit(input logic b);
    md_oe_o = 1'b1;
    md_o = b;
    #HALF_NS mdc_o = 1'b1;
    #HALF_NS mdc_o = 1'b0;
  endtask

  // the released line floats to its pull-up level unless the device drives it
  task automatic get_bit(output logic b);
    md_oe_o = 1'b0;
    #HALF_NS mdc_o = 1'b1;
    b = mdio_i;
    #HALF_NS mdc_o = 1'b0;
  endtask

  // the clock stands still low between frames
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
      input logic [15:0] wd, output logic [15:0] rd, output logic ta, output logic drv);
    logic [13:0] hdr;
    logic [17:0] wbits;
    logic b;
    int i;
    drove = 1'b0;
    rd = 16'h0000;
    ta = 1'b1;
    hdr = {2'b01, op, phy, rg};
    wbits = {2'b10, wd};
    for (i = 0; i < 32; i++) put_bit(1'b1);
    for (i = 13; i >= 0; i--) put_bit(hdr[i]);
    if (op == 2'b01) begin
      for (i = 17; i >= 0; i--) put_bit(wbits[i]);
    end else begin
      // first turnaround bit floats high, the device drives the second low
      get_bit(b);
      get_bit(ta);
      for (i = 0; i < 16; i++) begin
        get_bit(b);
        rd = {rd[14:0], b};
      end
    end
    get_bit(b);
    get_bit(b);
    drv = drove;
  endtask
endmodule

//--- rxp_pkg.sv
// types shared by the receive pin interface modules
package rxp_pkg;

  typedef enum logic [2:0] {
    MD_IDLE,
    MD_HDR,
    MD_TA,
    MD_RD,
    MD_WR
  } rxp_md_state_t;

  typedef struct packed {
    logic err;
    logic crs;
    logic dv;
    logic [3:0] d;
  } rxp_word_t;

  typedef struct packed {
    logic bootstrap_err;
    logic speed100;
    logic repeater;
    logic rmii_slave;
    logic rmii;
  } rxp_cfg_t;

endpackage

//--- rxp_rx_pins.sv
// receive pin interface and management pins of a 10/100 line interface
`timescale 1ns/1ps
`include "rxp_map.svh"
module rxp_rx_pins (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic por_b_i,
  input wire logic line_clk_i,
  input wire logic [3:0] line_d_i,
  input wire logic line_dv_i,
  input wire logic line_crs_i,
  input wire logic line_err_i,
  input wire logic [3:0] rx_d_i,
  output logic [3:0] rx_d_o,
  output logic rx_d_oe_o,
  input wire logic rx_dv_i,
  output logic rx_dv_o,
  output logic rx_dv_oe_o,
  input wire logic rx_er_i,
  output logic rx_er_o,
  output logic rx_er_oe_o,
  output logic rx_clk_o,
  output logic rx_clk_oe_o,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  output logic [4:0] cfg_o,
  output logic overrun_o
);

  // ==================================================
  // reset release
  logic [1:0] rst_sync;
  logic [1:0] por_sync;
  wire rst_src_b = rst_b_i & por_b_i;
  wire rst_n = rst_sync[1];
  wire por_n = por_sync[1];

  always_ff @(posedge ref_clk_i or negedge rst_src_b) begin
    if (!rst_src_b) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end

  always_ff @(posedge ref_clk_i or negedge por_b_i) begin
    if (!por_b_i) por_sync <= 2'h0;
    else por_sync <= {por_sync[0], 1'b1};
  end

  // ==================================================
  // pin synchronisers; the management clock is treated as foreign like any pin
  logic [15:0] meta;
  logic [15:0] sync;
  logic lclk_q;
  logic mdc_q;
  wire [15:0] raw = {line_clk_i, line_err_i, line_crs_i, line_dv_i, line_d_i,
                     rx_er_i, rx_dv_i, rx_d_i, mdc_i, mdio_i};

  always_ff @(posedge ref_clk_i or negedge rst_src_b) begin
    if (!rst_src_b) begin
      meta <= 16'h0000;
      sync <= 16'h0000;
      lclk_q <= 1'b0;
      mdc_q <= 1'b0;
    end else begin
      meta <= raw;
      sync <= meta;
      lclk_q <= sync[15];
      mdc_q <= sync[1];
    end
  end

  wire lclk_rise = sync[15] && !lclk_q;
  wire mdc_rise = sync[1] && !mdc_q;
  wire mdio_s = sync[0];
  wire [5:0] strap_pins = sync[7:2];
  rxp_pkg::rxp_word_t line_word;
  assign line_word = rxp_pkg::rxp_word_t'(sync[14:8]);

  // ==================================================
  // bootstrap capture, kept across pin resets
  rxp_pkg::rxp_cfg_t cfg;
  logic strap_done;

  always_ff @(posedge ref_clk_i or negedge por_n) begin
    if (!por_n) begin
      cfg <= rxp_pkg::rxp_cfg_t'(`RXP_CFG_RST);
      strap_done <= 1'b0;
    end else if (!strap_done && rst_n) begin
      cfg.rmii <= strap_pins[`RXP_STRAP_RMII];
      cfg.rmii_slave <= strap_pins[`RXP_STRAP_SLAVE];
      cfg.repeater <= strap_pins[`RXP_STRAP_REPEATER];
      cfg.speed100 <= strap_pins[`RXP_STRAP_SPEED100];
      cfg.bootstrap_err <= strap_pins[`RXP_STRAP_ERR];
      strap_done <= 1'b1;
    end
  end

  assign cfg_o = cfg;

  // ==================================================
  // line side: one word per recovered clock rise with dv, crs or err set into the buffer
  rxp_stream_if #(.W(`RXP_FIFO_WIDTH)) strm ();
  logic hold_v;
  rxp_pkg::rxp_word_t hold;
  logic overrun;
  wire take = lclk_rise && (line_word.dv || line_word.crs || line_word.err);
  wire pushed = hold_v && strm.wr_ready;

  assign strm.wr_valid = hold_v;
  assign strm.wr_data = hold;

  // a full buffer stalls the hold stage; a word arriving meanwhile is lost and flagged
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hold_v <= 1'b0;
      hold <= '0;
      overrun <= 1'b0;
    end else begin
      if (take && (!hold_v || pushed)) begin
        hold <= line_word;
        hold_v <= 1'b1;
      end else if (pushed) begin
        hold_v <= 1'b0;
      end
      if (take && hold_v && !pushed) overrun <= 1'b1;
    end
  end

  assign overrun_o = overrun;

  rxp_fifo #(
    .WIDTH(`RXP_FIFO_WIDTH),
    .DEPTH(`RXP_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .s(strm)
  );

  // ==================================================
  // receive clock divider
  logic [2:0] div_cnt;
  logic rx_clk_r;
  wire rmii_master = cfg.rmii && !cfg.rmii_slave;
  wire mii10 = !cfg.rmii && !cfg.speed100;
  wire [2:0] half_cyc = cfg.rmii ? 3'(`RXP_HALFRMII) :
                        cfg.speed100 ? 3'(`RXP_HALF100) : 3'(`RXP_HALF10);
  wire div_wrap = (div_cnt >= half_cyc - 3'h1);
  wire rise_tick = div_wrap && !rx_clk_r;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 3'h0;
      rx_clk_r <= 1'b0;
    end else if (div_wrap) begin
      div_cnt <= 3'h0;
      rx_clk_r <= !rx_clk_r;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // ==================================================
  // drain side: nibbles in mii; in rmii the low dibit, then the high dibit only for words with dv set
  logic phase;
  rxp_pkg::rxp_word_t cur;
  rxp_pkg::rxp_word_t rd_word;
  logic pins_on;
  assign rd_word = rxp_pkg::rxp_word_t'(strm.rd_data);
  wire want = rise_tick && (!cfg.rmii || !phase);
  wire rd_fire = want && strm.rd_valid;
  assign strm.rd_ready = want;
  wire rd_valid_ind = cfg.repeater ? rd_word.dv : (rd_word.dv || rd_word.crs);
  wire next_dv = cfg.rmii ? rd_valid_ind : rd_word.dv;
  wire [3:0] next_d = cfg.rmii ? {2'h0, rd_word.d[1:0]} : rd_word.d;

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      cur <= '0;
      rx_d_o <= 4'h0;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
    end else if (rise_tick) begin
      if (cfg.rmii && phase) begin
        rx_d_o <= {2'h0, cur.d[3:2]};
        phase <= 1'b0;
      end else if (rd_fire) begin
        cur <= rd_word;
        rx_d_o <= next_d;
        rx_dv_o <= next_dv;
        rx_er_o <= rd_word.err;
        phase <= cfg.rmii && rd_word.dv;
      end else begin
        rx_d_o <= 4'h0;
        rx_dv_o <= 1'b0;
        rx_er_o <= 1'b0;
      end
    end
  end

  // ==================================================
  // pin direction: inputs while in reset, outputs once straps are in; the receive clock stays an input for an rmii slave
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pins_on <= 1'b0;
      rx_clk_o <= 1'b0;
      rx_clk_oe_o <= 1'b0;
    end else begin
      pins_on <= strap_done;
      rx_clk_o <= rx_clk_r;
      rx_clk_oe_o <= strap_done && !(cfg.rmii && cfg.rmii_slave);
    end
  end

  assign rx_d_oe_o = pins_on;
  assign rx_dv_oe_o = pins_on;
  assign rx_er_oe_o = pins_on;

  // ==================================================
  // management frame slave
  rxp_pkg::rxp_md_state_t md_state;
  logic [5:0] pre_cnt;
  logic [4:0] bit_cnt;
  logic [11:0] hdr;
  logic [15:0] md_sh;
  wire [12:0] frame = {hdr, mdio_s};
  wire md_match = frame[12] && (frame[9:5] == `RXP_PHY_ADDR);
  wire [15:0] md_status = {10'h000, cfg, overrun};

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      md_state <= rxp_pkg::MD_IDLE;
      pre_cnt <= 6'h00;
      bit_cnt <= 5'h00;
      hdr <= 12'h000;
      md_sh <= 16'h0000;
      mdio_o <= 1'b0;
      mdio_oe_o <= 1'b0;
    end else if (mdc_rise) begin
      case (md_state)
        rxp_pkg::MD_IDLE: begin
          if (mdio_s) begin
            if (pre_cnt < `RXP_MD_PRE_BITS) pre_cnt <= pre_cnt + 6'h01;
          end else begin
            if (pre_cnt >= `RXP_MD_PRE_BITS) md_state <= rxp_pkg::MD_HDR;
            pre_cnt <= 6'h00;
            bit_cnt <= 5'h00;
          end
        end
        rxp_pkg::MD_HDR: begin
          hdr <= frame[11:0];
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `RXP_MD_HDR_LAST) begin
            bit_cnt <= 5'h00;
            if (md_match && frame[11:10] == `RXP_MD_OP_READ) md_state <= rxp_pkg::MD_TA;
            else if (md_match && frame[11:10] == `RXP_MD_OP_WRITE) md_state <= rxp_pkg::MD_WR;
            else md_state <= rxp_pkg::MD_IDLE;
          end
        end
        rxp_pkg::MD_TA: begin
          // first turnaround bit left released, second driven low
          mdio_oe_o <= 1'b1;
          mdio_o <= 1'b0;
          md_sh <= md_status;
          md_state <= rxp_pkg::MD_RD;
        end
        rxp_pkg::MD_RD: begin
          if (bit_cnt == `RXP_MD_DATA_BITS) begin
            mdio_oe_o <= 1'b0;
            md_state <= rxp_pkg::MD_IDLE;
          end else begin
            mdio_o <= md_sh[15];
            md_sh <= {md_sh[14:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
          end
        end
        rxp_pkg::MD_WR: begin
          // write data is accepted and discarded: nothing here is writable
          bit_cnt <= bit_cnt + 5'h01;
          if (bit_cnt == `RXP_MD_WR_BITS - 5'h01) md_state <= rxp_pkg::MD_IDLE;
        end
        default: md_state <= rxp_pkg::MD_IDLE;
      endcase
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n);

  property p_pins_after_straps;
    rx_d_oe_o |-> strap_done && rx_dv_oe_o && rx_er_oe_o;
  endproperty
  a_pins_after_straps: assert property (p_pins_after_straps) else $error("pins driven before straps");

  property p_mii_dv;
    !cfg.rmii && rd_fire |=> rx_dv_o == $past(rd_word.dv) && rx_d_o == $past(rd_word.d);
  endproperty
  a_mii_dv: assert property (p_mii_dv) else $error("mii nibble or valid wrong");

  property p_crs_dv;
    cfg.rmii && !cfg.repeater && rd_fire && rd_word.crs |=> rx_dv_o;
  endproperty
  a_crs_dv: assert property (p_crs_dv) else $error("crs_dv missed carrier");

  property p_repeater;
    cfg.rmii && cfg.repeater && rd_fire && !rd_word.dv |=> !rx_dv_o;
  endproperty
  a_repeater: assert property (p_repeater) else $error("repeater valid not pure");

  property p_edge_only;
    !$past(rise_tick) |-> $stable(rx_d_o) && $stable(rx_er_o) && $stable(rx_dv_o);
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("receive pins moved off edge");

  property p_err;
    rd_fire && rd_word.err |=> rx_er_o;
  endproperty
  a_err: assert property (p_err) else $error("error symbol not flagged");

  property p_slave_clk;
    cfg.rmii && cfg.rmii_slave |-> !rx_clk_oe_o;
  endproperty
  a_slave_clk: assert property (p_slave_clk) else $error("slave drives receive clock");

  property p_clk10;
    mii10 && $rose(rx_clk_r) |-> rx_clk_r[*4] ##1 !rx_clk_r;
  endproperty
  a_clk10: assert property (p_clk10) else $error("10 Mbps clock half period wrong");

  property p_rmii_clk;
    rmii_master && $past(rmii_master) |=> rx_clk_o != $past(rx_clk_o);
  endproperty
  a_rmii_clk: assert property (p_rmii_clk) else $error("rmii reference not toggling");

  property p_rmii_width;
    cfg.rmii |-> rx_d_o[3:2] == 2'h0;
  endproperty
  a_rmii_width: assert property (p_rmii_width) else $error("rmii upper data bits set");

  property p_strap_keep;
    @(posedge ref_clk_i) disable iff (!por_n) strap_done |=> $stable(cfg);
  endproperty
  a_strap_keep: assert property (p_strap_keep) else $error("straps recaptured");

  property p_turnaround;
    md_state == rxp_pkg::MD_TA && mdc_rise |=> mdio_oe_o && !mdio_o ##0 md_state == rxp_pkg::MD_RD;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("turnaround not driven low");

  c_mii_frame: cover property (!cfg.rmii && rx_dv_o ##1 rx_dv_o);
  c_rmii_frame: cover property (cfg.rmii && rx_dv_o && rx_d_oe_o);
  c_md_read: cover property (md_state == rxp_pkg::MD_RD && mdio_oe_o);
  c_overrun: cover property ($rose(overrun));

endmodule

//--- rxp_rx_pins_bench.sv
// self-checking bench for the receive pin interface and management pins
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module rxp_rx_pins_bench;
  // ==================================================
  // pins and wires
  logic ref_clk_i, rst_b_i, por_b_i, line_clk_i, line_dv_i, line_crs_i, line_err_i;
  logic [3:0] line_d_i, rx_d_o, strap_d;
  logic rx_d_oe_o, rx_dv_o, rx_dv_oe_o, rx_er_o, rx_er_oe_o, rx_clk_o, rx_clk_oe_o;
  logic mdio_o, mdio_oe_o, overrun_o, strap_er, st_oe, st_d, mdc_w;
  logic [4:0] cfg_o, cur_cfg;
  wire logic [3:0] rx_d_i;
  wire logic rx_dv_i, rx_er_i, mdio_w;
  int mismatches, comparisons;
  logic [6:0] exp_q[$];
  logic [6:0] e_w;
  logic chk_on, rmii, rep, clk_prev;
  logic [4:0] modes [0:4] = '{5'h00, 5'h18, 5'h01, 5'h05, 5'h03};

  // straps show while the pins are inputs; the pull-up holds the idle data line high
  assign rx_d_i = rx_d_oe_o ? rx_d_o : strap_d;
  assign rx_dv_i = rx_dv_oe_o ? rx_dv_o : 1'b0;
  assign rx_er_i = rx_er_oe_o ? rx_er_o : strap_er;
  assign mdio_w = mdio_oe_o ? mdio_o : (st_oe ? st_d : 1'b1);

  rxp_rx_pins dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .por_b_i(por_b_i),
    .line_clk_i(line_clk_i), .line_d_i(line_d_i), .line_dv_i(line_dv_i),
    .line_crs_i(line_crs_i), .line_err_i(line_err_i), .rx_d_i(rx_d_i), .rx_d_o(rx_d_o),
    .rx_d_oe_o(rx_d_oe_o), .rx_dv_i(rx_dv_i), .rx_dv_o(rx_dv_o), .rx_dv_oe_o(rx_dv_oe_o),
    .rx_er_i(rx_er_i), .rx_er_o(rx_er_o), .rx_er_oe_o(rx_er_oe_o), .rx_clk_o(rx_clk_o),
    .rx_clk_oe_o(rx_clk_oe_o), .mdc_i(mdc_w), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .cfg_o(cfg_o), .overrun_o(overrun_o));

  rxp_mgmt_station st (.mdio_i(mdio_w), .dev_oe_i(mdio_oe_o), .mdc_o(mdc_w),
    .md_oe_o(st_oe), .md_o(st_d));

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // ==================================================
  // monitor: words are judged one cycle after the receive clock rises
  always @(posedge ref_clk_i) begin
    clk_prev <= rx_clk_o;
    if (chk_on && rx_clk_o && !clk_prev && (rx_dv_o || rx_er_o)) begin
      if (exp_q.size() == 0) `CHK("extra word", 1'b0, 1'b1)
      else begin
        e_w = exp_q.pop_front();
        `CHK("rx word", e_w, {rx_er_o, rx_dv_o, rx_d_o})
      end
    end
  end

  // ==================================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic power_up(input logic [4:0] s);
    {strap_er, strap_d} = s;
    por_b_i = 1'b0;
    rst_b_i = 1'b0;
    tick(4);
    `CHK("oe in reset", 3'b000, {rx_d_oe_o, rx_dv_oe_o, rx_er_oe_o})
    por_b_i = 1'b1;
    rst_b_i = 1'b1;
    tick(10);
    cur_cfg = s;
    rmii = s[0];
    rep = s[2];
    `CHK("cfg", cur_cfg, cfg_o)
    `CHK("pins out", 3'b111, {rx_d_oe_o, rx_dv_oe_o, rx_er_oe_o})
    `CHK("overrun clear", 1'b0, overrun_o)
  endtask

  // the link clock runs only within frames, off the system clock's phase
  task automatic send_word(input logic [3:0] d, input logic dv, crs, er, input int hn);
    logic vd;
    vd = rep ? dv : (dv | crs);
    if (!rmii && (dv || er)) exp_q.push_back({er, dv, d});
    else if (rmii && dv) begin
      exp_q.push_back({er, 1'b1, 2'b00, d[1:0]});
      exp_q.push_back({er, 1'b1, 2'b00, d[3:2]});
    end else if (rmii && (vd || er)) exp_q.push_back({er, vd, 2'b00, d[1:0]});
    {line_d_i, line_dv_i, line_crs_i, line_err_i} = {d, dv, crs, er};
    #hn line_clk_i = 1'b1;
    #hn line_clk_i = 1'b0;
  endtask

  task automatic frame(input int n);
    int i;
    #13;
    for (i = 0; i < n; i++) send_word(4'($urandom), 1'b1, 1'b1, i == n / 2, 200);
    send_word(4'h0, 1'b0, 1'b0, 1'b1, 200);
    send_word(4'h0, 1'b0, 1'b1, 1'b0, 200);
    {line_d_i, line_dv_i, line_crs_i, line_err_i} = 7'h00;
    tick(60);
    `CHK("drained", 0, exp_q.size())
  endtask

  task automatic clk_period(input int p);
    int k, r1, r2;
    logic q;
    r1 = -1;
    r2 = -1;
    q = rx_clk_o;
    for (k = 0; k < 40; k++) begin
      @(negedge ref_clk_i);
      if (rx_clk_o && !q) begin
        if (r1 < 0) r1 = k;
        else if (r2 < 0) r2 = k;
      end
      q = rx_clk_o;
    end
    `CHK("rx clk period", p, r2 - r1)
  endtask

  task automatic mgmt(input logic [1:0] op, input logic [4:0] phy, input logic drive);
    logic [15:0] rd;
    logic ta, drv;
    st.frame(op, phy, 5'h03, 16'($urandom), rd, ta, drv);
    tick(4);
    `CHK("mdio drive", drive, drv)
    if (drive) begin
      `CHK("turnaround", 1'b0, ta)
      // reads only follow the overrun scenario, so the sticky flag is expected set
      `CHK("mdio read", {10'h000, cur_cfg, 1'b1}, rd)
    end
    `CHK("mdio released", 1'b0, mdio_oe_o)
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==================================================
  // main sequence
  initial begin
    int m;
    {rst_b_i, por_b_i, line_clk_i, line_dv_i, line_crs_i, line_err_i} = 6'h00;
    {line_d_i, strap_d, strap_er, clk_prev, chk_on, rmii, rep} = 13'h0000;
    mismatches = 0;
    comparisons = 0;
    void'($urandom(32'h69E7DBB0));
    for (m = 0; m < 5; m++) begin
      power_up(modes[m]);
      if (modes[m][1]) begin
        `CHK("rx clk oe", 1'b0, rx_clk_oe_o)
      end else begin
        `CHK("rx clk oe", 1'b1, rx_clk_oe_o)
        clk_period((modes[m][0] || modes[m][3]) ? 2 : 8);
        chk_on = 1'b1;
        frame(12);
        chk_on = 1'b0;
      end
      if (m == 0) begin
        // line faster than the 10M receive clock: the buffer fills and words are lost
        repeat (40) send_word(4'hA, 1'b1, 1'b1, 1'b0, 100);
        tick(400);
        exp_q.delete();
        `CHK("overrun", 1'b1, overrun_o)
        mgmt(2'b10, 5'h01, 1'b1);
        mgmt(2'b10, 5'h02, 1'b0);
        mgmt(2'b01, 5'h01, 1'b0);
      end
      if (m == 1) begin
        {strap_er, strap_d} = 5'h03;
        rst_b_i = 1'b0;
        tick(4);
        rst_b_i = 1'b1;
        tick(10);
        `CHK("cfg kept", cur_cfg, cfg_o)
      end
    end
    print_verdict();
  end

  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
endmodule

//--- rxp_stream_if.sv
// valid/ready stream between the pin logic and its receive buffer
`timescale 1ns/1ps
interface rxp_stream_if #(parameter int W = 7);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;

  modport fifo (input wr_valid, input wr_data, output wr_ready,
                output rd_valid, output rd_data, input rd_ready);
  modport user (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
endinterface
